//--- design/cssu_top.sv
// Clock source decoder, start-up timer and trim register
`timescale 1ns/100ps
module cssu_top
    import cssu_pkg::*;
#(
    parameter int WAKE_32K_CYC = 32768,
    parameter int RST_DLY_64K_CYC = 65536
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Fuse pins and the stored 1 MHz calibration byte
    input wire cssu_fuse_s fuse_pins,
    input wire logic [7:0] cal_byte_1mhz,
    // Source clocks, sampled on ref_clk
    input wire logic lf_xtal_clk,
    input wire logic ext_rc_clk,
    input wire logic int_rc_clk,
    input wire logic oscillator_input_pin,
    input wire logic wdt_osc_clk,
    // Sleep control from the power manager
    input wire logic sleep_req,
    input wire logic wake_req,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Decoded selection
    output cssu_src_e src_sel,
    output logic [1:0] src_range,
    output logic cap_in_en,
    output logic cap_out_en,
    output logic [7:0] rc_trim,
    // Timing results
    output logic cpu_rst_hold,
    output logic sys_clk_en,
    output logic sys_clk_tick,
    output logic wdt_tick
);
    // Sequencer states
    typedef enum logic [2:0] {
        ST_SETTLE, ST_RST_DLY, ST_RUN, ST_SLEEP, ST_WAKE
    } cssu_state_e;

    localparam int SYNC_W = 5;                  // Clock inputs synchronised

    cssu_state_e state_r, state_nxt;            // Sequencer
    cssu_fuse_s fuse_s1_r, fuse_s2_r;           // Fuse synchroniser
    cssu_fuse_s fuse_r;                         // Captured fuses
    logic [7:0] cal_s1_r, cal_s2_r;             // Calibration byte synchroniser
    logic [SYNC_W-1:0] clk_s1_r, clk_s2_r;      // Clock synchroniser
    logic [SYNC_W-1:0] clk_s3_r;                // Edge detect history
    logic [1:0] settle_r;                       // Synchroniser settle count
    logic [CNT_W-1:0] cnt_r, cnt_nxt;           // Delay counter
    logic [7:0] trim_r;                         // Oscillator trim register
    logic [7:0] rdata_r;                        // Read data

    // Inputs from outside this clock domain, two stages each
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fuse_s1_r <= '1;
            fuse_s2_r <= '1;
            cal_s1_r <= 8'h00;
            cal_s2_r <= 8'h00;
            clk_s1_r <= '0;
            clk_s2_r <= '0;
            clk_s3_r <= '0;
        end else begin
            fuse_s1_r <= fuse_pins;
            fuse_s2_r <= fuse_s1_r;
            cal_s1_r <= cal_byte_1mhz;
            cal_s2_r <= cal_s1_r;
            clk_s1_r <= {wdt_osc_clk, oscillator_input_pin, int_rc_clk,
                         ext_rc_clk, lf_xtal_clk};
            clk_s2_r <= clk_s1_r;
            clk_s3_r <= clk_s2_r;
        end
    end

    // Rising edge of each sampled clock
    wire [SYNC_W-1:0] clk_rise = clk_s2_r & ~clk_s3_r;

    // Fuse field views, bit value 0 means programmed
    wire [3:0] src_code = fuse_r.clock_source_select_fuses;              // R19
    wire [1:0] stup_code = fuse_r.startup_time_fuses;
    wire opt_prog = (fuse_r.oscillator_option_fuse == FUSE_PROGRAMMED); // R19

    // Source decode
    wire is_lf = (src_code == SRCSEL_LF_XTAL);                           // R1
    wire is_erc = (src_code >= SRCSEL_ERC_LO) && (src_code <= SRCSEL_ERC_HI); // R5
    wire is_irc = (src_code >= SRCSEL_IRC_LO) && (src_code <= SRCSEL_IRC_HI); // R9
    wire is_ext = (src_code == SRCSEL_EXT_CLK);                          // R14
    wire cssu_src_e src_dec = is_lf ? SRC_LF_XTAL :
                              is_erc ? SRC_EXT_RC :
                              is_irc ? SRC_INT_RC :
                              is_ext ? SRC_EXT_CLK : SRC_OTHER;

    // Frequency range within the family: internal RC 0..3 = 1/2/4/8 MHz
    wire [1:0] range_irc = 2'(src_code - SRCSEL_IRC_LO);                 // R9
    wire [1:0] range_erc = 2'(src_code - SRCSEL_ERC_LO);                 // R5
    wire [1:0] range_dec = is_irc ? range_irc : is_erc ? range_erc : 2'h0;

    // Load capacitors switched in by the programmed option fuse
    wire cap_in_dec = opt_prog && (is_lf || is_erc || is_ext);           // R2 R6
    wire cap_out_dec = opt_prog && is_lf;                                // R2

    // Wake-up length in selected source cycles
    wire [CNT_W-1:0] wake_lf = (stup_code == STUP_10) ? CNT_W'(WAKE_32K_CYC)
                                               : CNT_W'(WAKE_1K_CYC);    // R3
    wire [CNT_W-1:0] wake_erc = (stup_code == STUP_11) ? CNT_W'(WAKE_SHORT_CYC)
                                                : CNT_W'(WAKE_RC_CYC);   // R7
    wire [CNT_W-1:0] wake_len = is_lf ? wake_lf :
                                is_erc ? wake_erc :
                                CNT_W'(WAKE_SHORT_CYC);                  // R13 R15

    // Extra reset delay in watchdog cycles, zero means none
    wire [CNT_W-1:0] dly_4k = CNT_W'(RST_DLY_4K_CYC);                    // R18
    wire [CNT_W-1:0] dly_64k = CNT_W'(RST_DLY_64K_CYC);                  // R18
    wire [CNT_W-1:0] dly_lf = (stup_code == STUP_00) ? dly_4k : dly_64k; // R3
    wire [CNT_W-1:0] dly_gen = (stup_code == STUP_00) ? '0 :
                               (stup_code == STUP_01) ? dly_4k : dly_64k; // R7 R13 R15
    wire [CNT_W-1:0] rst_dly_len = is_lf ? dly_lf : dly_gen;

    // Tick selection: watchdog for reset delay, source for wake-up
    wire wdt_rise = clk_rise[4];                                         // R12
    wire src_rise = is_lf ? clk_rise[0] :
                    is_erc ? clk_rise[1] :
                    is_irc ? clk_rise[2] :
                    is_ext ? clk_rise[3] : 1'b0;
    wire cnt_done = (cnt_r == '0);

    // Sequencer next state and counter
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            ST_SETTLE: begin
                // Fuses captured here, length chosen from them next
                if (settle_r == SETTLE_CYC) begin
                    state_nxt = ST_RST_DLY;
                    cnt_nxt = rst_dly_len;
                end
            end
            ST_RST_DLY: begin
                // Reset delay paced by watchdog oscillator
                if (cnt_done) begin
                    state_nxt = ST_RUN;                                  // R18
                end else if (wdt_rise) begin
                    cnt_nxt = cnt_r - CNT_W'(1);                         // R12
                end
            end
            ST_RUN: begin
                // Normal operation until sleep
                if (sleep_req) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                // Source restarts, load wake length
                if (wake_req) begin
                    state_nxt = ST_WAKE;
                    cnt_nxt = wake_len;
                end
            end
            ST_WAKE: begin
                // Wake-up paced by the selected source clock
                if (cnt_done) begin
                    state_nxt = ST_RUN;
                end else if (src_rise) begin
                    cnt_nxt = cnt_r - CNT_W'(1);                         // R3 R7
                end
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_SETTLE;
            cnt_r <= '0;
            settle_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            if (state_r == ST_SETTLE) begin
                settle_r <= settle_r + 2'h1;
            end
        end
    end

    // Fuses taken once after reset release, then frozen
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fuse_r <= '1;
        end else if (state_r == ST_SETTLE && settle_r == SETTLE_CYC - 2'h1) begin
            fuse_r <= fuse_s2_r;                                         // R20
        end
    end

    // Register decode
    wire wr_trim = reg_wr && (reg_addr == REG_TRIM);
    wire load_cal = (state_r == ST_SETTLE) && (settle_r == SETTLE_CYC);
    wire run_lvl = (state_r == ST_RUN);
    wire [7:0] status_val = {run_lvl, 1'b0, range_dec, opt_prog, 3'(src_dec)};
    wire [7:0] rd_mux = (reg_addr == REG_TRIM) ? trim_r :
                        (reg_addr == REG_STATUS) ? status_val :
                        (reg_addr == REG_FUSES) ? {1'b0, fuse_r} : 8'h00;

    // Trim register, calibration byte loaded during reset sequence
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            trim_r <= TRIM_RST;
        end else if (load_cal) begin
            trim_r <= cal_s2_r;                                          // R10
        end else if (wr_trim) begin
            trim_r <= reg_wdata;
        end
    end

    // Read data, valid the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            rdata_r <= rd_mux;
        end
    end

    // Registered decode outputs
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            src_sel <= SRC_OTHER;
            src_range <= 2'h0;
            cap_in_en <= 1'b0;
            cap_out_en <= 1'b0;
            sys_clk_tick <= 1'b0;
            wdt_tick <= 1'b0;
        end else begin
            src_sel <= src_dec;
            src_range <= range_dec;
            cap_in_en <= cap_in_dec;
            cap_out_en <= cap_out_dec;
            sys_clk_tick <= src_rise && run_lvl;
            wdt_tick <= wdt_rise;                                        // R12
        end
    end

    // Output assignments
    assign reg_rdata = rdata_r;
    assign rc_trim = trim_r;
    assign sys_clk_en = run_lvl;
    assign cpu_rst_hold = (state_r == ST_SETTLE) || (state_r == ST_RST_DLY);

endmodule : cssu_top

//--- include/cssu_pkg.sv
// Constants, types and codes for the clock source and start-up selector
// What this block does and what its users must do
// R1: Fuse pattern 1001 selects low-frequency crystal
// R2: Option fuse adds capacitors on both crystal pins
// R3: Crystal start-up 1K/1K/32K, reset delays per code
// R4: Short crystal wake only when stability unimportant
// R5: Codes 0101-0111 select external RC, 1000 reserved
// R6: Option fuse adds input capacitor in RC mode
// R7: RC wake 18 cycles, code 11 six cycles
// R8: Avoid six-cycle RC wake near maximum frequency
// R9: Codes 0001-0100 select internal RC 1/2/4/8 MHz
// R10: Reset loads 1 MHz trim byte automatically
// R11: Leave option fuse unprogrammed with internal RC
// R12: Watchdog oscillator still times watchdog and reset
// R13: Internal RC wake six cycles, reset delay per code
// R14: Code 0000 takes clock from oscillator input pin
// R15: External clock wake six cycles, delay per code
// R16: External clock changes under two percent per cycle
// R17: Timer oscillator pins carry watch crystal only
// R18: Reset delay counts 4K or 64K watchdog cycles
// R19: Fuse bit reads 1 unprogrammed, 0 programmed
// R20: Fuses sampled once at reset, reserved codes untested
package cssu_pkg;
    // Fuse group, raw bits: 1 means unprogrammed
    typedef struct packed {
        logic       oscillator_option_fuse;
        logic [1:0] startup_time_fuses;
        logic [3:0] clock_source_select_fuses;
    } cssu_fuse_s;
    // Decoded clock source
    typedef enum logic [2:0] {
        SRC_EXT_CLK, SRC_INT_RC, SRC_EXT_RC, SRC_LF_XTAL, SRC_OTHER
    } cssu_src_e;
    // Clock source selection codes
    localparam logic [3:0] SRCSEL_EXT_CLK = 4'h0;
    localparam logic [3:0] SRCSEL_IRC_LO = 4'h1;
    localparam logic [3:0] SRCSEL_IRC_HI = 4'h4;
    localparam logic [3:0] SRCSEL_ERC_LO = 4'h5;
    localparam logic [3:0] SRCSEL_ERC_HI = 4'h7;
    localparam logic [3:0] SRCSEL_LF_XTAL = 4'h9;
    // Start-up time codes
    localparam logic [1:0] STUP_00 = 2'h0;
    localparam logic [1:0] STUP_01 = 2'h1;
    localparam logic [1:0] STUP_10 = 2'h2;
    localparam logic [1:0] STUP_11 = 2'h3;
    // Programmed fuse level
    localparam logic FUSE_PROGRAMMED = 1'h0;
    // Wake-up lengths in source clock cycles
    localparam int WAKE_SHORT_CYC = 6;
    localparam int WAKE_RC_CYC = 18;
    localparam int WAKE_1K_CYC = 1024;
    // Reset delay lengths in watchdog oscillator cycles
    localparam int RST_DLY_4K_CYC = 4096;
    // Counter width, covers the longest count
    localparam int CNT_W = 17;
    // Register indices
    localparam logic [1:0] REG_TRIM = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam logic [1:0] REG_FUSES = 2'h2;
    // Reset values
    localparam logic [7:0] TRIM_RST = 8'h00;
    // Cycles the fuse synchroniser needs before capture
    localparam logic [1:0] SETTLE_CYC = 2'h3;
endpackage : cssu_pkg

//--- dv/cssu_src_model.sv
// Far-side clock sources and watchdog oscillator for the selector
`timescale 1ns/100ps
module cssu_src_model (
    // Selectable source clocks
    output logic lf_xtal_clk = 1'b0,
    output logic ext_rc_clk = 1'b0,
    output logic int_rc_clk = 1'b0,
    output logic oscillator_input_pin = 1'b0,
    // Watchdog oscillator
    output logic wdt_osc_clk = 1'b0
);
    // Watch crystal, steady period, nothing else on it
    // Half periods are multiples of 10 ns, so no edge meets a ref_clk rise
    always #60 lf_xtal_clk = ~lf_xtal_clk;
    // RC network and internal RC oscillator
    always #50 ext_rc_clk = ~ext_rc_clk;
    always #30 int_rc_clk = ~int_rc_clk;
    // Driven clock with a fixed period, no cycle-to-cycle drift
    always #40 oscillator_input_pin = ~oscillator_input_pin;
    // Watchdog oscillator, free running
    always #40 wdt_osc_clk = ~wdt_osc_clk;
endmodule : cssu_src_model

//--- dv/cssu_top_chk.sv
// Port-level assertions for the clock source selector
`timescale 1ns/100ps
module cssu_top_chk
    import cssu_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Register writes and sleep control
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic sleep_req,
    input wire logic wake_req,
    // Decode and timing outputs
    input wire cssu_src_e src_sel,
    input wire logic [1:0] src_range,
    input wire logic cap_in_en,
    input wire logic cap_out_en,
    input wire logic [7:0] rc_trim,
    input wire logic cpu_rst_hold,
    input wire logic sys_clk_en,
    input wire logic sys_clk_tick,
    input wire logic wdt_tick
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Run ends and the core stops
    sequence s_run_drop; sys_clk_en ##1 !sys_clk_en; endsequence
    // Wake request taken while asleep
    sequence s_wake_taken; !sys_clk_en && !cpu_rst_hold && wake_req; endsequence
    property p_cap_out; cap_out_en |-> src_sel == SRC_LF_XTAL; endproperty
    a_cap_out: assert property (p_cap_out) else $error("pin cap outside crystal");
    property p_cap_in; cap_in_en |-> src_sel != SRC_INT_RC && src_sel != SRC_OTHER; endproperty
    a_cap_in: assert property (p_cap_in) else $error("input cap in wrong mode");
    property p_excl; !(sys_clk_en && cpu_rst_hold); endproperty
    a_excl: assert property (p_excl) else $error("run during reset delay");
    property p_tick; sys_clk_tick |-> sys_clk_en || $past(sys_clk_en); endproperty
    a_tick: assert property (p_tick) else $error("source tick outside run");
    property p_wdt; wdt_tick |=> !wdt_tick; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog tick too long");
    property p_hold; sys_clk_en |=> $stable(src_sel) && $stable(src_range); endproperty
    a_hold: assert property (p_hold) else $error("decode moved while running");
    property p_erc_rng; src_sel == SRC_EXT_RC |-> src_range <= 2'h2; endproperty
    a_erc_rng: assert property (p_erc_rng) else $error("bad RC range");
    property p_trim; sys_clk_en && reg_wr && reg_addr == REG_TRIM |=> rc_trim == $past(reg_wdata);
    endproperty
    a_trim: assert property (p_trim) else $error("trim write lost");
    property p_sleep; sys_clk_en && sleep_req |-> ##[1:2] !sys_clk_en; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not entered");
    property p_wake_rst; s_run_drop |-> !cpu_rst_hold; endproperty
    a_wake_rst: assert property (p_wake_rst) else $error("reset delay on sleep");
    property p_wake_min; s_wake_taken |=> !sys_clk_en [*8]; endproperty
    a_wake_min: assert property (p_wake_min) else $error("wake too short");
endmodule : cssu_top_chk
bind cssu_top cssu_top_chk i_cssu_top_chk (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .sleep_req, .wake_req, .src_sel, .src_range, .cap_in_en, .cap_out_en, .rc_trim,
    .cpu_rst_hold, .sys_clk_en, .sys_clk_tick, .wdt_tick);

//--- dv/test_cssu_top.sv
// Self-checking bench for the clock source selector
`timescale 1ns/100ps
module test_cssu_top import cssu_pkg::*;;
    // Stimulus and observed outputs
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    cssu_fuse_s fuse_pins = 7'h7f;
    logic [7:0] cal_byte_1mhz = 8'h5a;
    logic sleep_req = 1'b0, wake_req = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [1:0] reg_addr = 2'h0, src_range;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, rc_trim;
    logic lf_xtal_clk, ext_rc_clk, int_rc_clk, oscillator_input_pin, wdt_osc_clk;
    cssu_src_e src_sel;
    logic cap_in_en, cap_out_en, cpu_rst_hold, sys_clk_en, sys_clk_tick, wdt_tick;
    int fails = 0, check_count = 0;
    // Clocks indexed by source code, watchdog last
    wire [4:0] clks = {wdt_osc_clk, lf_xtal_clk, ext_rc_clk, int_rc_clk, oscillator_input_pin};
    always #5 ref_clk = ~ref_clk;
    cssu_top #(.WAKE_32K_CYC(40), .RST_DLY_64K_CYC(50)) i_cssu_top (.ref_clk, .rst_b,
        .fuse_pins, .cal_byte_1mhz, .lf_xtal_clk, .ext_rc_clk, .int_rc_clk,
        .oscillator_input_pin, .wdt_osc_clk, .sleep_req, .wake_req, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .src_sel, .src_range, .cap_in_en, .cap_out_en,
        .rc_trim, .cpu_rst_hold, .sys_clk_en, .sys_clk_tick, .wdt_tick);
    cssu_src_model i_cssu_src_model (.lf_xtal_clk, .ext_rc_clk, .int_rc_clk,
        .oscillator_input_pin, .wdt_osc_clk);
    // Value compare
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // Edge count compare, allows sampling skew
    task automatic chk_cnt(input int got, input int exp, input string m);
        check_count++;
        if (got < exp - 1 || got > exp + 2) begin
            fails++;
            $display("[ERR] %0t %s count %0d exp %0d", $time, m, got, exp);
        end
    endtask : chk_cnt
    // Register read, data taken the cycle after the strobe
    task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
        @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge ref_clk) reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read
    // Register write, one strobe cycle
    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge ref_clk) reg_wr <= 1'b0;
    endtask : reg_write
    // Counts rising edges of one clock until the core runs
    task automatic count_to_run(input int k, output int n);
        logic p;
        int t;
        n = 0;
        p = clks[k];
        for (t = 0; t < 60000 && sys_clk_en !== 1'b1; t++) begin
            @(posedge ref_clk);
            #1 n += (clks[k] && !p) ? 1 : 0;
            p = clks[k];
        end
    endtask : count_to_run
    // One pulse on a sleep control input
    task automatic pulse(input bit w);
        @(posedge ref_clk) {wake_req, sleep_req} <= {w, !w};
        @(posedge ref_clk) {wake_req, sleep_req} <= 2'b00;
        repeat (3) @(posedge ref_clk);
    endtask : pulse
    // Reset with given fuses, then reset delay, decode, sleep and wake
    task automatic run_cfg(input logic [6:0] f, input cssu_src_e s, input logic [1:0] r,
                           input int dly, input int wake, input string m);
        int n;
        logic [7:0] d;
        @(posedge ref_clk) {rst_b, fuse_pins} <= {1'b0, f};
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        count_to_run(4, n);
        chk_cnt(n, dly, "reset delay");
        chk({s, r}, {src_sel, src_range}, "source");
        chk(cap_in_en, !f[6] && s != SRC_INT_RC, "cap in");
        chk(cap_out_en, !f[6] && s == SRC_LF_XTAL, "cap out");
        chk(rc_trim, cal_byte_1mhz, "trim load");
        reg_read(REG_STATUS, d);
        chk(d, {2'b10, r, !f[6], s}, "status");
        reg_read(REG_FUSES, d);
        chk(d, {1'b0, f}, "fuse reg");
        fuse_pins <= ~f;
        pulse(1'b0);
        chk(sys_clk_en, 1'b0, "asleep");
        pulse(1'b1);
        count_to_run(s, n);
        chk_cnt(n, wake, "wake");
        chk(src_sel, s, "held");
        $display("test %s done", m);
    endtask : run_cfg
    // Watch crystal, short wake only where stability is irrelevant
    task automatic t_lf;
        run_cfg(7'b0_01_1001, SRC_LF_XTAL, 2'h0, 50, 1024, "lf short");
        run_cfg(7'b1_10_1001, SRC_LF_XTAL, 2'h0, 50, 40, "lf long");
    endtask : t_lf
    // RC network, six-cycle wake run at the highest range code 0111
    task automatic t_erc;
        run_cfg(7'b1_00_0110, SRC_EXT_RC, 2'h1, 0, 18, "rc mid");
        run_cfg(7'b0_11_0111, SRC_EXT_RC, 2'h2, 50, 6, "rc high");
        run_cfg(7'b1_10_0101, SRC_EXT_RC, 2'h0, 50, 18, "rc low");
    endtask : t_erc
    // Internal RC, all four codes, option left unprogrammed
    task automatic t_irc;
        for (int i = 1; i < 5; i++) begin
            run_cfg({1'b1, i[0], 1'b0, i[3:0]}, SRC_INT_RC, 2'(i - 1), i[0] ? 50 : 0, 6, "irc");
        end
    endtask : t_irc
    // Driven clock with the 4K reset delay, then trim and unmapped access
    task automatic t_ext;
        logic [7:0] d;
        run_cfg(7'b0_01_0000, SRC_EXT_CLK, 2'h0, 4096, 6, "ext");
        reg_write(REG_TRIM, 8'ha5);
        reg_read(REG_TRIM, d);
        chk(d, 8'ha5, "trim rw");
        reg_write(2'h3, 8'hff);
        reg_read(2'h3, d);
        chk(d, 8'h00, "unmapped");
    endtask : t_ext
    // Verdict and end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    // Main sequence
    initial begin
        t_lf();
        t_erc();
        t_irc();
        t_ext();
        close_out();
    end
    // Hang guard, well beyond the expected run
    initial begin
        #900000;
        fails++;
        close_out();
    end
endmodule : test_cssu_top
